// file: rds_pkg.sv
`default_nettype none

package rds_pkg;

  // pclk timing
  localparam int unsigned CLK_PERIOD_NS = 100;

  // least low time before a brown-out trips, in ns; rounded up to pclk cycles
  localparam int unsigned BROWN_MIN_NS  = 100000;
  localparam int unsigned BROWN_MIN_CYC = (BROWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter widths and counts
  localparam int                CNT_W            = 11;
  localparam logic [CNT_W-1:0]  OSC_SETTLE_CYC   = 11'h400;
  localparam logic [CNT_W-1:0]  DELAY_RC_CYC_DEF = 11'h048;
  localparam logic [CNT_W-1:0]  BROWN_MIN_CNT    = CNT_W'(BROWN_MIN_CYC);

  // register map, byte addresses
  localparam int               ADDR_W   = 8;
  localparam logic [ADDR_W-1:0] CFG_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RST_BIT   = 4;
  localparam int STAT_WAKE_BIT  = 5;
  localparam int STAT_POR_BIT   = 8;
  localparam int STAT_BROWN_BIT = 9;

  typedef enum logic [1:0] {
    OSC_RC,
    OSC_LOWPWR,
    OSC_STD,
    OSC_FAST
  } rds_osc_t;

  // configuration word, bit 5 down to bit 0
  typedef struct packed {
    logic       delay_en_n;
    logic       brown_en;
    logic [1:0] brown_level;
    rds_osc_t   osc_mode;
  } rds_cfg_t;

  localparam int       CFG_W   = 6;
  localparam rds_cfg_t CFG_RST = 6'h10;

  typedef enum logic [2:0] {
    ST_WAIT,
    ST_BROWNOUT,
    ST_DELAY,
    ST_SETTLE,
    ST_RUN
  } rds_state_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rds_apb_req_t;

endpackage : rds_pkg

`default_nettype wire

// file: rds_edge_counter.sv
`timescale 1ns/1ps
`default_nettype none

// counts rising edges of a slow tick level while run is high
module rds_edge_counter (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clear,
  input  wire logic                      run,
  input  wire logic                      tick,
  input  wire logic [rds_pkg::CNT_W-1:0] target,
  output logic                           done
);

  logic                      tick_q;
  logic                      tick_d;
  logic [rds_pkg::CNT_W-1:0] cnt_q;
  logic [rds_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    tick_d = tick;
    cnt_d  = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (run && tick && !tick_q && cnt_q != target) begin
      cnt_d = cnt_q + 11'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      tick_q <= tick_d;
      cnt_q  <= cnt_d;
    end
  end

  assign done = run && !clear && (cnt_q == target);

endmodule : rds_edge_counter

`default_nettype wire

// file: rds_low_filter.sv
`timescale 1ns/1ps
`default_nettype none

// trips only when the low indication has stood for the full minimum time
module rds_low_filter (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic low,
  output logic      trip
);

  logic [rds_pkg::CNT_W-1:0] cnt_q;
  logic [rds_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = '0;
    if (enable && low) begin
      cnt_d = (cnt_q == rds_pkg::BROWN_MIN_CNT) ? cnt_q : cnt_q + 11'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // a short dip restarts the count from zero
  assign trip = enable && low && (cnt_q == rds_pkg::BROWN_MIN_CNT);

endmodule : rds_low_filter

`default_nettype wire

// file: rds_reset_sequencer.sv
// Operation
// - delay timer only for power-up type resets
// - power-on pulse starts the delay timer
// - brown-out end starts the delay timer
// - delay timer counts internal rc oscillator
// - chip reset held while delay runs
// - enable bit gates delay for power-on only
// - settle counter waits 1024 oscillator cycles
// - settle only in crystal modes, power-up/wake
// - four trip levels by two-bit field
// - enable bit switches brown-out reset
// - brown-out needs low beyond minimum time
// - stay in brown-out until supply recovers
// - low during delay re-enters brown-out, restarts
// - supply rise pulse starts power-up sequence
`timescale 1ns/1ps
`default_nettype none

module rds_reset_sequencer #(
  parameter logic [rds_pkg::CNT_W-1:0] DELAY_RC_CYC = rds_pkg::DELAY_RC_CYC_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        por_pulse,
  input  wire logic [3:0]  supply_low,
  input  wire logic        rc_osc,
  input  wire logic        external_oscillator_input,
  input  wire logic        wake_pulse,
  output logic             chip_reset,
  output logic             wake_hold
);

  rds_pkg::rds_apb_req_t req;
  rds_pkg::rds_cfg_t     cfg_q;
  rds_pkg::rds_cfg_t     cfg_d;
  rds_pkg::rds_state_t   st_q;
  rds_pkg::rds_state_t   st_d;
  logic                  wake_q;
  logic                  wake_d;
  logic                  rst_q;
  logic                  rst_d;
  logic                  wk_q;
  logic                  wk_d;
  logic                  por_flag_q;
  logic                  por_flag_d;
  logic                  brown_flag_q;
  logic                  brown_flag_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;
  logic                  low_now;
  logic                  brown_trip;
  logic                  delay_done;
  logic                  settle_done;
  logic                  xtal;
  logic                  wr_en;
  logic                  mapped;

  function automatic logic is_xtal(input rds_pkg::rds_osc_t mode);
    return (mode == rds_pkg::OSC_LOWPWR) || (mode == rds_pkg::OSC_STD) ||
           (mode == rds_pkg::OSC_FAST);
  endfunction : is_xtal

  function automatic logic hold_reset(input rds_pkg::rds_state_t st, input logic wk);
    return (st != rds_pkg::ST_RUN) && !(st == rds_pkg::ST_SETTLE && wk);
  endfunction : hold_reset

  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata;

  // ---------------- bus slave ----------------
  assign mapped  = (req.paddr == rds_pkg::CFG_OFS) || (req.paddr == rds_pkg::STAT_OFS);
  assign wr_en   = req.psel && req.penable && req.pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = req.psel && req.penable && !mapped;
  assign prdata  = rdata_q;

  always_comb begin
    rdata_d = rdata_q;
    // read data captured in the setup cycle so it is a flop in the access cycle
    if (req.psel && !req.penable) begin
      rdata_d = 32'h0000_0000;
      if (req.paddr == rds_pkg::CFG_OFS) begin
        rdata_d[rds_pkg::CFG_W-1:0] = cfg_q;
      end else if (req.paddr == rds_pkg::STAT_OFS) begin
        rdata_d[rds_pkg::STAT_STATE_LSB +: 3] = st_q;
        rdata_d[rds_pkg::STAT_RST_BIT]        = rst_q;
        rdata_d[rds_pkg::STAT_WAKE_BIT]       = wk_q;
        rdata_d[rds_pkg::STAT_POR_BIT]        = por_flag_q;
        rdata_d[rds_pkg::STAT_BROWN_BIT]      = brown_flag_q;
      end
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    if (wr_en && req.paddr == rds_pkg::CFG_OFS) begin
      cfg_d = rds_pkg::rds_cfg_t'(req.pwdata[rds_pkg::CFG_W-1:0]);
    end
  end

  // ---------------- supply detection ----------------
  // trip level select
  assign low_now = supply_low[cfg_q.brown_level];
  assign xtal    = is_xtal(cfg_q.osc_mode);

  rds_low_filter u_low_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (cfg_q.brown_en),
    .low     (low_now),
    .trip    (brown_trip)
  );

  rds_edge_counter u_delay_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (st_q != rds_pkg::ST_DELAY || por_pulse),
    .run     (st_q == rds_pkg::ST_DELAY),
    .tick    (rc_osc),
    .target  (DELAY_RC_CYC),
    .done    (delay_done)
  );

  rds_edge_counter u_settle_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (st_q != rds_pkg::ST_SETTLE),
    .run     (st_q == rds_pkg::ST_SETTLE),
    .tick    (external_oscillator_input),
    .target  (rds_pkg::OSC_SETTLE_CYC),
    .done    (settle_done)
  );

  // ---------------- sequencer ----------------
  always_comb begin
    st_d   = st_q;
    wake_d = wake_q;
    if (por_pulse) begin
      wake_d = 1'b0;
      if (!cfg_q.delay_en_n) begin
        st_d = rds_pkg::ST_DELAY;
      end else begin
        st_d = xtal ? rds_pkg::ST_SETTLE : rds_pkg::ST_RUN;
      end
    end else if (cfg_q.brown_en &&
                 (brown_trip || (st_q == rds_pkg::ST_DELAY && low_now))) begin
      wake_d = 1'b0;
      st_d   = rds_pkg::ST_BROWNOUT;
    end else begin
      case (st_q)
        rds_pkg::ST_WAIT: begin
          st_d = rds_pkg::ST_WAIT;
        end
        rds_pkg::ST_BROWNOUT: begin
          if (!low_now || !cfg_q.brown_en) begin
            st_d = rds_pkg::ST_DELAY;
          end
        end
        rds_pkg::ST_DELAY: begin
          if (delay_done) begin
            st_d = xtal ? rds_pkg::ST_SETTLE : rds_pkg::ST_RUN;
          end
        end
        rds_pkg::ST_SETTLE: begin
          if (settle_done) begin
            st_d   = rds_pkg::ST_RUN;
            wake_d = 1'b0;
          end
        end
        rds_pkg::ST_RUN: begin
          if (wake_pulse && xtal) begin
            st_d   = rds_pkg::ST_SETTLE;
            wake_d = 1'b1;
          end
        end
        default: begin
          st_d = rds_pkg::ST_WAIT;
        end
      endcase
    end
  end

  always_comb begin
    rst_d      = hold_reset(st_d, wake_d);
    wk_d       = (st_d == rds_pkg::ST_SETTLE) && wake_d;
    // hardware set wins over a software clear in the same cycle
    por_flag_d   = por_flag_q;
    brown_flag_d = brown_flag_q;
    if (wr_en && req.paddr == rds_pkg::STAT_OFS) begin
      if (req.pwdata[rds_pkg::STAT_POR_BIT]) begin
        por_flag_d = 1'b0;
      end
      if (req.pwdata[rds_pkg::STAT_BROWN_BIT]) begin
        brown_flag_d = 1'b0;
      end
    end
    if (por_pulse) begin
      por_flag_d = 1'b1;
    end
    if (st_d == rds_pkg::ST_BROWNOUT && st_q != rds_pkg::ST_BROWNOUT) begin
      brown_flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q      <= rds_pkg::CFG_RST;
      st_q       <= rds_pkg::ST_WAIT;
      wake_q     <= 1'b0;
      rst_q      <= 1'b1;
      wk_q       <= 1'b0;
      por_flag_q <= 1'b0;
      brown_flag_q <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      cfg_q      <= cfg_d;
      st_q       <= st_d;
      wake_q     <= wake_d;
      rst_q      <= rst_d;
      wk_q       <= wk_d;
      por_flag_q <= por_flag_d;
      brown_flag_q <= brown_flag_d;
      rdata_q    <= rdata_d;
    end
  end

  assign chip_reset = rst_q;
  assign wake_hold  = wk_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_settle_exit;
    st_q == rds_pkg::ST_SETTLE ##1 st_q == rds_pkg::ST_RUN;
  endsequence

  property p_delay_source;
    $rose(st_q == rds_pkg::ST_DELAY) |->
      $past(por_pulse) || $past(st_q) == rds_pkg::ST_BROWNOUT;
  endproperty
  a_delay_source: assert property (p_delay_source)
    else $error("delay timer started without power-up reset");

  property p_por_start;
    por_pulse && !cfg_q.delay_en_n |=> st_q == rds_pkg::ST_DELAY && chip_reset;
  endproperty
  a_por_start: assert property (p_por_start)
    else $error("power-on pulse did not start delay");

  property p_brown_end;
    st_q == rds_pkg::ST_BROWNOUT && !low_now && !por_pulse |=> st_q == rds_pkg::ST_DELAY;
  endproperty
  a_brown_end: assert property (p_brown_end)
    else $error("brown-out end did not start delay");

  property p_hold_in_delay;
    st_q inside {rds_pkg::ST_WAIT, rds_pkg::ST_BROWNOUT, rds_pkg::ST_DELAY} |-> chip_reset;
  endproperty
  a_hold_in_delay: assert property (p_hold_in_delay)
    else $error("chip reset released during delay");

  property p_por_bypass;
    por_pulse && cfg_q.delay_en_n |=> st_q != rds_pkg::ST_DELAY;
  endproperty
  a_por_bypass: assert property (p_por_bypass)
    else $error("disabled delay ran on power-on");

  property p_settle_done;
    s_settle_exit |-> $past(settle_done);
  endproperty
  a_settle_done: assert property (p_settle_done)
    else $error("settle counter left early");

  property p_settle_xtal;
    $rose(st_q == rds_pkg::ST_SETTLE) |-> $past(xtal);
  endproperty
  a_settle_xtal: assert property (p_settle_xtal)
    else $error("settle counter used outside crystal mode");

  property p_brown_enable;
    $rose(st_q == rds_pkg::ST_BROWNOUT) |-> $past(cfg_q.brown_en);
  endproperty
  a_brown_enable: assert property (p_brown_enable)
    else $error("brown-out reset while disabled");

  property p_dip_restart;
    st_q == rds_pkg::ST_DELAY && low_now && cfg_q.brown_en && !por_pulse
      |=> st_q == rds_pkg::ST_BROWNOUT ##1 chip_reset;
  endproperty
  a_dip_restart: assert property (p_dip_restart)
    else $error("supply dip during delay not caught");

endmodule : rds_reset_sequencer

`default_nettype wire

// file: rds_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

// free-running oscillators and one supply comparator per trip level
module rds_supply_model (
  input  wire logic       pclk,
  input  wire logic [2:0] vdd,
  output logic      [3:0] supply_low,
  output logic            rc_osc,
  output logic            osc_out
);
  logic [1:0] div_q = 2'h0;
  logic [1:0] div_d;

  always_comb div_d = div_q + 2'h1;
  always_ff @(posedge pclk) div_q <= div_d;
  // four pclk per oscillator cycle keeps edges countable
  assign rc_osc  = div_q[1];
  assign osc_out = ~div_q[1];

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      supply_low[k] = (vdd <= 3'(k));
    end
  end
endmodule : rds_supply_model

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [10:0] P  = 11'h004;
  localparam int          PW = 16;
  logic        pclk, presetn, psel, penable, pwrite, por_pulse, wake_pulse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, chip_reset, wake_hold, rc_osc, osc_out, er;
  logic [3:0]  supply_low;
  logic [2:0]  vdd;
  int          miscompares = 0;
  int          n_compared = 0;
  int          c;

  rds_reset_sequencer #(.DELAY_RC_CYC(P)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .por_pulse(por_pulse),
    .supply_low(supply_low), .rc_osc(rc_osc),
    .external_oscillator_input(osc_out), .wake_pulse(wake_pulse),
    .chip_reset(chip_reset), .wake_hold(wake_hold));

  rds_supply_model sup (.pclk(pclk), .vdd(vdd), .supply_low(supply_low),
    .rc_osc(rc_osc), .osc_out(osc_out));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      results();
    end
  endtask : acc

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    acc(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rchk

  // one-cycle pulse on the wake input when wk is set, else on the power-on input
  task pulse(input bit wk);
    @(posedge pclk);
    if (wk) begin
      wake_pulse <= 1'b1;
    end else begin
      por_pulse <= 1'b1;
    end
    @(posedge pclk);
    wake_pulse <= 1'b0;
    por_pulse  <= 1'b0;
  endtask : pulse

  // bounded wait for reset release, cycle count checked against a window
  task rel(input int lo, input int hi);
    c = 0;
    while (chip_reset !== 1'b0 && c < hi) begin
      @(posedge pclk);
      c++;
    end
    chk("release_cycles", 32'h1, 32'(c >= lo && c < hi));
    if (c >= hi) results();
  endtask : rel

  task hold_low(input logic [2:0] v, input int n);
    @(posedge pclk);
    vdd <= v;
    cyc(n);
    vdd <= 3'h7;
  endtask : hold_low

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; por_pulse = 1'b0; wake_pulse = 1'b0; vdd = 3'h7;
    cyc(12);
    presetn <= 1'b1;
    rchk("cfg_reset", 8'h00, 32'hFFFFFFFF, 32'h10);
    chk("held_before_por", 1, chip_reset);
    acc(1'b0, 8'h08, 32'h0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    acc(1'b1, 8'h0C, 32'h3F);
    acc(1'b1, 8'h00, 32'hFFFFFFC0);
    rchk("cfg_width", 8'h00, 32'hFFFFFFFF, 32'h0);
    acc(1'b1, 8'h00, 32'h10);
    pulse(1'b0);
    rel(PW - 8, PW + 12);
    pulse(1'b0);
    rchk("state_delay", 8'h04, 32'h7, rds_pkg::ST_DELAY);
    rel(1, PW + 12);
    rchk("por_flag", 8'h04, 32'h100, 32'h100);
    acc(1'b1, 8'h04, 32'h100);
    rchk("por_flag_clr", 8'h04, 32'h100, 32'h0);
    // crystal mode adds the settle count after the delay
    acc(1'b1, 8'h00, 32'h12);
    pulse(1'b0);
    cyc(PW + 6);
    rchk("state_settle", 8'h04, 32'h7, rds_pkg::ST_SETTLE);
    rel(4 * 1024 - 30, 4 * 1024 + 10);
    pulse(1'b1);
    cyc(2);
    chk("wake_hold", 1, wake_hold);
    chk("wake_no_reset", 0, chip_reset);
    cyc(4200);
    chk("wake_done", 0, wake_hold);
    acc(1'b1, 8'h00, 32'h30);
    pulse(1'b0);
    rel(0, 4);
    rchk("state_bypass", 8'h04, 32'h7, rds_pkg::ST_RUN);
    pulse(1'b1);
    cyc(2);
    chk("wake_rc_ignored", 0, wake_hold);
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 8'h00, 32'h30 | (k << 2));
      hold_low(3'(k + 1), 1100);
      chk("above_level", 0, chip_reset);
      hold_low(3'(k), 500);
      chk("short_low", 0, chip_reset);
      @(posedge pclk);
      vdd <= 3'(k);
      cyc(1010);
      chk("trip", 1, chip_reset);
      rchk("state_brownout", 8'h04, 32'h7, rds_pkg::ST_BROWNOUT);
      vdd <= 3'h7;
      rchk("state_after_brownout", 8'h04, 32'h7, rds_pkg::ST_DELAY);
      rel(4, PW + 12);
    end
    rchk("brown_flag", 8'h04, 32'h200, 32'h200);
    hold_low(3'h3, 1010);
    cyc(10);
    hold_low(3'h3, 2);
    rel(PW - 6, PW + 12);
    acc(1'b1, 8'h00, 32'h0C);
    hold_low(3'h3, 1100);
    chk("brown_disabled", 0, chip_reset);
    results();
  end
endmodule : tb

`default_nettype wire
